// *** phyvr_pkg.sv ***
// Constants, types and decode helpers for the paged register block.
// Assumes a single 200 MHz device clock and the page selector held
// outside this block in base register 7.
`default_nettype none

package phyvr_pkg;

   // Clock and soft reset pulse timing
   localparam int CLK_PERIOD_NS  = 5;
   localparam int SWRST_PULSE_NS = 20;
   localparam int SWRST_CNT_W    = 3;
   localparam logic [SWRST_CNT_W-1:0] SWRST_CYC =
      SWRST_CNT_W'((SWRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [SWRST_CNT_W-1:0] SWRST_CNT_ZERO = 3'h0;
   localparam logic [SWRST_CNT_W-1:0] SWRST_CNT_ONE  = 3'h1;

   // Page selector values
   localparam logic [2:0] PG_IDENT  = 3'h1;
   localparam logic [2:0] PG_VENDOR = 3'h7;

   // Paged addresses (the paged window is 1000b to 1111b)
   localparam int         PAGED_BIT        = 3;
   localparam logic [3:0] ADDR_COMPLIANCE  = 4'h8;
   localparam logic [3:0] ADDR_MAKER_HI    = 4'hA;
   localparam logic [3:0] ADDR_MAKER_MID   = 4'hB;
   localparam logic [3:0] ADDR_MAKER_LO    = 4'hC;
   localparam logic [3:0] ADDR_PART_HI     = 4'hD;
   localparam logic [3:0] ADDR_PART_MID    = 4'hE;
   localparam logic [3:0] ADDR_PART_LO     = 4'hF;
   localparam logic [3:0] ADDR_VCTRL       = 4'h8;
   localparam logic [3:0] ADDR_SOFT_RESET  = 4'hE;

   // Register contents and field positions; position 0 is the data LSB
   localparam logic [7:0] COMPLIANCE_VAL  = 8'h01;
   localparam logic [7:0] READ_ZERO       = 8'h00;
   localparam int         NULL_FLAG_BIT   = 7;
   localparam int         SPEED_MSB       = 1;
   localparam int         SPEED_LSB       = 0;
   localparam int         SOFT_RESET_BIT  = 7;
   localparam logic       NULL_FLAG_RST   = 1'b0;

   typedef logic [1:0] phyvr_speed_t;
   localparam phyvr_speed_t SPD_S100 = 2'h0;
   localparam phyvr_speed_t SPD_S200 = 2'h1;
   localparam phyvr_speed_t SPD_S400 = 2'h2;
   localparam phyvr_speed_t SPEED_RST = SPD_S400;

   // Received packet lengths
   localparam int                PKT_LEN_W = 16;
   localparam logic [PKT_LEN_W-1:0] ACK_BITS = 16'h0008;

   function automatic logic reg_hit(input logic [2:0] pg,
                                    input logic [3:0] ad,
                                    input logic [2:0] want_pg,
                                    input logic [3:0] want_ad);
      return (pg == want_pg) && (ad == want_ad);
   endfunction

endpackage

`default_nettype wire

// *** phyvr_ctrl_if.sv ***
// Control fields shared between the register block and its helpers.
// Driven only by the top module; helpers read it.
`default_nettype none

interface phyvr_ctrl_if;
   import phyvr_pkg::*;
   logic         null_flag;
   phyvr_speed_t link_speed;
   logic         hard_rst;
   modport owner (output null_flag, output link_speed, output hard_rst);
   modport user  (input  null_flag, input  link_speed, input  hard_rst);
endinterface

`default_nettype wire

// *** phyvr_req_clear.sv ***
// Decides whether a received packet clears pending fair and priority
// requests. Packet end and length come from receive logic on sys_clk.
`default_nettype none

module phyvr_req_clear (
   input  wire logic                      sys_clk,
   phyvr_ctrl_if.user                     ctrl,
   input  wire logic                      arb_accel_en,
   input  wire logic                      pkt_end,
   input  wire logic [phyvr_pkg::PKT_LEN_W-1:0] pkt_bits,
   output var  logic                      clear_q
);
   import phyvr_pkg::*;

   typedef struct packed {
      logic clear;
   } phyvr_rc_state_t;

   phyvr_rc_state_t st_q;
   phyvr_rc_state_t st_d;

   always_comb begin
      st_d = '0;
      if (pkt_end) begin
         if (ctrl.null_flag && arb_accel_en) begin
            st_d.clear = (pkt_bits > ACK_BITS); // R6
         end else begin
            st_d.clear = (pkt_bits != ACK_BITS); // R7
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (ctrl.hard_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign clear_q = st_q.clear;

   default clocking rc_cb @(posedge sys_clk); endclocking
   default disable iff (ctrl.hard_rst);

   keep_short_a: assert property ( // R6
      pkt_end && ctrl.null_flag && arb_accel_en && (pkt_bits <= ACK_BITS)
      |=> !clear_q)
      else $error("short packet cleared requests with flag set");

   clear_non_ack_a: assert property ( // R7
      pkt_end && !ctrl.null_flag && (pkt_bits != ACK_BITS) |=> clear_q)
      else $error("non-ack packet failed to clear requests");

endmodule // phyvr_req_clear

`default_nettype wire

// *** phyvr_top.sv ***
// Paged register block: identification page and vendor-dependent page.
// Requests arrive from the link-layer controller request decoder on the
// same clock; the page selector comes from base register 7.
`default_nettype none

// Summary of operation
// R1: Page value 1 shows identification registers 1000b-1111b.
// R2: Address 1000b reads compliance level 01h.
// R3: Maker identifier spans 1010b-1100b, MSB first.
// R4: Part identifier spans 1101b-1111b, MSB first.
// R5: Page value 7 shows vendor control page.
// R6: Flag set, acceleration on: clear only long packets.
// R7: Flag clear: any non-acknowledge packet clears requests.
// R8: Null-packet flag at 1000b, reset 0.
// R9: Link speed field at 1000b, two bits.
// R10: Link speed copied into self-ID speed.
// R11: Peers always see S400 capability.
// R12: Hard reset sets link speed to S400.
// R13: Writing soft reset bit forces full reset.
// R14: Soft reset bit always reads zero.
// R15: Reserved bits read zero, writes ignored.
module phyvr_top #(
   parameter logic [23:0] MAKER_ID = 24'h5A_C3_71, // Arbitrary value
   parameter logic [23:0] PART_ID  = 24'h00_4D_2E  // Arbitrary value
) (
   input  wire logic                         sys_clk,
   input  wire logic                         sys_rst,
   input  wire logic [2:0]                   page_select,
   input  wire logic                         reg_rd_req,
   input  wire logic                         reg_wr_req,
   input  wire logic [3:0]                   reg_addr,
   input  wire logic [7:0]                   reg_wdata,
   input  wire logic                         bus_rst,
   input  wire logic                         arb_accel_en,
   input  wire logic                         pkt_end,
   input  wire logic [phyvr_pkg::PKT_LEN_W-1:0] pkt_bits,
   output var  logic [7:0]                   reg_rdata,
   output var  logic                         reg_rd_valid,
   output var  logic                         null_packet_keep_requests,
   output var  phyvr_pkg::phyvr_speed_t      link_speed,
   output var  phyvr_pkg::phyvr_speed_t      selfid_speed,
   output var  phyvr_pkg::phyvr_speed_t      peer_speed_cap,
   output var  logic                         soft_hard_reset,
   output var  logic                         clear_requests
);
   import phyvr_pkg::*;

   typedef struct packed {
      logic                   null_flag;
      phyvr_speed_t           link_speed;
      phyvr_speed_t           selfid_speed;
      phyvr_speed_t           peer_speed;
      logic                   soft_rst;
      logic [SWRST_CNT_W-1:0] rst_cnt;
      logic [7:0]             rdata;
      logic                   rd_valid;
   } phyvr_top_state_t;

   phyvr_top_state_t st_q;
   phyvr_top_state_t st_d;

   phyvr_ctrl_if ctrl ();

   // Requests are refused while the soft reset pulse runs
   logic req_ok;
   logic wr_vctrl;
   logic wr_soft_reset;
   logic paged;
   logic [7:0] rd_byte;

   assign req_ok = !st_q.soft_rst;
   assign paged  = reg_addr[PAGED_BIT];

   assign wr_vctrl = reg_wr_req && req_ok
                     && reg_hit(page_select, reg_addr, PG_VENDOR, ADDR_VCTRL);
   assign wr_soft_reset = reg_wr_req && req_ok
                     && reg_hit(page_select, reg_addr, PG_VENDOR,
                                ADDR_SOFT_RESET)
                     && reg_wdata[SOFT_RESET_BIT];

   // Read decode of the two pages
   always_comb begin
      rd_byte = READ_ZERO;
      if (page_select == PG_IDENT) begin // R1
         case (reg_addr)
            ADDR_COMPLIANCE: rd_byte = COMPLIANCE_VAL;  // R2
            ADDR_MAKER_HI:   rd_byte = MAKER_ID[23:16]; // R3
            ADDR_MAKER_MID:  rd_byte = MAKER_ID[15:8];  // R3
            ADDR_MAKER_LO:   rd_byte = MAKER_ID[7:0];   // R3
            ADDR_PART_HI:    rd_byte = PART_ID[23:16];  // R4
            ADDR_PART_MID:   rd_byte = PART_ID[15:8];   // R4
            ADDR_PART_LO:    rd_byte = PART_ID[7:0];    // R4
            default:         rd_byte = READ_ZERO;       // R15
         endcase
      end else if (page_select == PG_VENDOR) begin // R5
         case (reg_addr)
            ADDR_VCTRL: begin
               rd_byte[NULL_FLAG_BIT]         = st_q.null_flag;  // R8
               rd_byte[SPEED_MSB:SPEED_LSB]   = st_q.link_speed; // R9
            end
            // Soft reset bit and test space read back as zero
            default:    rd_byte = READ_ZERO; // R14 R15
         endcase
      end
   end

   always_comb begin
      st_d          = st_q;
      st_d.rd_valid = 1'b0;
      st_d.rdata    = READ_ZERO;

      // Only the paged window of pages 1 and 7 belongs to this block
      if (reg_rd_req && req_ok && paged
          && (page_select == PG_IDENT || page_select == PG_VENDOR)) begin
         st_d.rd_valid = 1'b1;
         st_d.rdata    = rd_byte;
      end

      if (wr_vctrl) begin
         st_d.null_flag  = reg_wdata[NULL_FLAG_BIT];        // R8
         st_d.link_speed = reg_wdata[SPEED_MSB:SPEED_LSB];  // R9
      end

      // Self-ID reports the link speed; peers always see S400
      st_d.selfid_speed = st_q.link_speed; // R10
      st_d.peer_speed   = SPD_S400;        // R11

      if (st_q.soft_rst) begin
         // Whole device held in reset for the pulse length
         st_d.null_flag  = NULL_FLAG_RST; // R13
         st_d.link_speed = SPEED_RST;     // R13
         st_d.rst_cnt    = st_q.rst_cnt - SWRST_CNT_ONE;
         if (st_q.rst_cnt == SWRST_CNT_ONE) begin
            st_d.soft_rst = 1'b0;
         end
      end else if (wr_soft_reset) begin
         st_d.soft_rst = 1'b1; // R13
         st_d.rst_cnt  = SWRST_CYC;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st_q              <= '0;
         st_q.null_flag    <= NULL_FLAG_RST; // R8
         st_q.link_speed   <= SPEED_RST;     // R12
         st_q.selfid_speed <= SPEED_RST;
         st_q.peer_speed   <= SPD_S400;
         st_q.rst_cnt      <= SWRST_CNT_ZERO;
      end else begin
         st_q <= st_d;
      end
   end

   // Shared control fields for the helper logic
   assign ctrl.null_flag  = st_q.null_flag;
   assign ctrl.link_speed = st_q.link_speed;
   assign ctrl.hard_rst   = sys_rst || st_q.soft_rst;

   phyvr_req_clear u_req_clear (
      .sys_clk      (sys_clk),
      .ctrl         (ctrl.user),
      .arb_accel_en (arb_accel_en),
      .pkt_end      (pkt_end),
      .pkt_bits     (pkt_bits),
      .clear_q      (clear_requests)
   );

   assign reg_rdata                 = st_q.rdata;
   assign reg_rd_valid              = st_q.rd_valid;
   assign null_packet_keep_requests = st_q.null_flag;
   assign link_speed                = st_q.link_speed;
   assign selfid_speed              = st_q.selfid_speed;
   assign peer_speed_cap            = st_q.peer_speed;
   assign soft_hard_reset           = st_q.soft_rst;

   // Checks on the register and reset paths
   default clocking top_cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence rd_at(logic [2:0] pg, logic [3:0] ad);
      reg_rd_req && req_ok && page_select == pg && reg_addr == ad;
   endsequence

   sequence swr_write;
      wr_soft_reset;
   endsequence

   sequence swr_pulse;
      soft_hard_reset [*4] ##1 !soft_hard_reset;
   endsequence

   sequence vnd_test_rd;
      reg_rd_req && req_ok && paged && page_select == PG_VENDOR
      && reg_addr != ADDR_VCTRL;
   endsequence

   compliance_read_a: assert property ( // R2
      rd_at(PG_IDENT, ADDR_COMPLIANCE) |=>
         reg_rd_valid && reg_rdata == COMPLIANCE_VAL)
      else $error("compliance level read wrong");

   maker_hi_read_a: assert property ( // R3
      rd_at(PG_IDENT, ADDR_MAKER_HI) |=>
         reg_rd_valid && reg_rdata == MAKER_ID[23:16])
      else $error("maker identifier high byte wrong");

   part_lo_read_a: assert property ( // R4
      rd_at(PG_IDENT, ADDR_PART_LO) |=>
         reg_rd_valid && reg_rdata == PART_ID[7:0])
      else $error("part identifier low byte wrong");

   vctrl_read_a: assert property ( // R5
      rd_at(PG_VENDOR, ADDR_VCTRL) |=>
         reg_rd_valid
         && reg_rdata[NULL_FLAG_BIT] == $past(null_packet_keep_requests)
         && reg_rdata[SPEED_MSB:SPEED_LSB] == $past(link_speed))
      else $error("vendor control read wrong");

   swr_reads_zero_a: assert property ( // R14
      rd_at(PG_VENDOR, ADDR_SOFT_RESET) |=> reg_rdata == READ_ZERO)
      else $error("soft reset bit read nonzero");

   reserved_zero_a: assert property ( // R15
      reg_rd_req && req_ok && page_select == PG_IDENT
      && reg_addr == ADDR_COMPLIANCE + 4'h1 |=> reg_rdata == READ_ZERO)
      else $error("reserved address read nonzero");

   vctrl_write_a: assert property ( // R8
      wr_vctrl |=>
         null_packet_keep_requests == $past(reg_wdata[NULL_FLAG_BIT])
         && link_speed == $past(reg_wdata[SPEED_MSB:SPEED_LSB]))
      else $error("vendor control write lost");

   ident_write_ignored_a: assert property ( // R1
      reg_wr_req && page_select == PG_IDENT && !st_q.soft_rst |=>
         $stable(null_packet_keep_requests) && $stable(link_speed))
      else $error("identification page write changed state");

   bus_reset_keeps_a: assert property ( // R12
      bus_rst && !reg_wr_req && !soft_hard_reset |=>
         $stable(null_packet_keep_requests) && $stable(link_speed))
      else $error("bus reset changed control fields");

   selfid_copy_a: assert property ( // R10
      ##1 selfid_speed == $past(link_speed))
      else $error("self-ID speed not following link speed");

   peer_s400_a: assert property ( // R11
      peer_speed_cap == SPD_S400)
      else $error("peer speed capability not S400");

   swr_pulse_a: assert property ( // R13
      swr_write |=> swr_pulse)
      else $error("soft reset pulse wrong length");

   swr_defaults_a: assert property ( // R13
      soft_hard_reset |=>
         null_packet_keep_requests == NULL_FLAG_RST
         && link_speed == SPEED_RST && !reg_rd_valid)
      else $error("soft reset did not restore defaults");

   base_window_silent_a: assert property ( // R1
      reg_rd_req && !reg_addr[PAGED_BIT] |=> !reg_rd_valid)
      else $error("answered a base register read");

   maker_mid_read_a: assert property ( // R3
      rd_at(PG_IDENT, ADDR_MAKER_MID) |=>
         reg_rd_valid && reg_rdata == MAKER_ID[15:8])
      else $error("maker identifier middle byte wrong");

   maker_lo_read_a: assert property ( // R3
      rd_at(PG_IDENT, ADDR_MAKER_LO) |=>
         reg_rd_valid && reg_rdata == MAKER_ID[7:0])
      else $error("maker identifier low byte wrong");

   part_hi_read_a: assert property ( // R4
      rd_at(PG_IDENT, ADDR_PART_HI) |=>
         reg_rd_valid && reg_rdata == PART_ID[23:16])
      else $error("part identifier high byte wrong");

   part_mid_read_a: assert property ( // R4
      rd_at(PG_IDENT, ADDR_PART_MID) |=>
         reg_rd_valid && reg_rdata == PART_ID[15:8])
      else $error("part identifier middle byte wrong");

   ident_valid_a: assert property ( // R1
      reg_rd_req && req_ok && paged && page_select == PG_IDENT |=>
         reg_rd_valid)
      else $error("identification page read not answered");

   test_space_zero_a: assert property ( // R15
      vnd_test_rd |=> reg_rd_valid && reg_rdata == READ_ZERO)
      else $error("test space read nonzero");

   vctrl_rsvd_zero_a: assert property ( // R15
      rd_at(PG_VENDOR, ADDR_VCTRL) |=>
         reg_rdata[NULL_FLAG_BIT-1:SPEED_MSB+1] == '0)
      else $error("reserved control bits read nonzero");

   other_page_silent_a: assert property ( // R5
      reg_rd_req && page_select != PG_IDENT && page_select != PG_VENDOR
      |=> !reg_rd_valid)
      else $error("answered a read on a foreign page");

   no_req_silent_a: assert property ( // R1
      !reg_rd_req |=> !reg_rd_valid)
      else $error("read answer without a request");

   idle_rdata_zero_a: assert property ( // R15
      !reg_rd_valid |-> reg_rdata == READ_ZERO)
      else $error("read data not zero while idle");

   test_write_ignored_a: assert property ( // R15
      reg_wr_req && page_select == PG_VENDOR && reg_addr != ADDR_VCTRL
      && !soft_hard_reset |=>
         $stable(null_packet_keep_requests) && $stable(link_speed))
      else $error("test space write changed control fields");

   fields_hold_a: assert property ( // R8
      !wr_vctrl && !soft_hard_reset |=>
         $stable(null_packet_keep_requests) && $stable(link_speed))
      else $error("control fields changed without a write");

   swr_bit_only_a: assert property ( // R13
      reg_wr_req && req_ok && !reg_wdata[SOFT_RESET_BIT]
      && reg_hit(page_select, reg_addr, PG_VENDOR, ADDR_SOFT_RESET)
      |=> !soft_hard_reset)
      else $error("soft reset started without its bit");

   swr_blocks_rd_a: assert property ( // R13
      reg_rd_req && soft_hard_reset |=> !reg_rd_valid)
      else $error("read answered during soft reset");

   swr_clear_quiet_a: assert property ( // R13
      soft_hard_reset |=> !clear_requests)
      else $error("requests cleared during soft reset");

   clear_needs_pkt_a: assert property ( // R7
      !pkt_end |=> !clear_requests)
      else $error("requests cleared without a packet");

   hard_reset_defaults_a: assert property ( // R12
      disable iff (1'b0)
      sys_rst |=> null_packet_keep_requests == NULL_FLAG_RST
                  && link_speed == SPEED_RST && !reg_rd_valid)
      else $error("hard reset did not restore defaults");

endmodule // phyvr_top

`default_nettype wire

// *** phyvr_llc_model.sv ***
// Link-layer controller model issuing paged register requests.
// Assumes the register block answers a read one cycle after taking it.
`default_nettype none

module phyvr_llc_model (
   input  wire logic       sys_clk,
   output var  logic [2:0] page_select,
   output var  logic       reg_rd_req,
   output var  logic       reg_wr_req,
   output var  logic [3:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rd_valid
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      page_select = 3'h0;
      reg_rd_req  = 1'b0;
      reg_wr_req  = 1'b0;
      reg_addr    = 4'h0;
      reg_wdata   = 8'h00;
   end

   // Idle address and data show the inverse, never a stale value
   task automatic wr(input logic [2:0] pg, input logic [3:0] ad,
                     input logic [7:0] d);
      @(posedge sys_clk);
      page_select <= pg;
      reg_addr    <= ad;
      reg_wdata   <= d;
      reg_wr_req  <= 1'b1;
      @(posedge sys_clk);
      reg_wr_req  <= 1'b0;
      reg_addr    <= ~ad;
      reg_wdata   <= ~d;
      #1;
   endtask

   task automatic rd(input logic [2:0] pg, input logic [3:0] ad,
                     output logic [7:0] d, output logic v);
      @(posedge sys_clk);
      page_select <= pg;
      reg_addr    <= ad;
      reg_rd_req  <= 1'b1;
      @(posedge sys_clk);
      reg_rd_req  <= 1'b0;
      reg_addr    <= ~ad;
      #1;
      d = reg_rdata;
      v = reg_rd_valid;
   endtask
endmodule // phyvr_llc_model

`default_nettype wire

// *** phy_vendor_register_pages_bench.sv ***
// Self-checking bench for the paged register block.
// Assumes phyvr_pkg, phyvr_ctrl_if, phyvr_req_clear, phyvr_top and phyvr_llc_model.
`default_nettype none

module phy_vendor_register_pages_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import phyvr_pkg::*;

   localparam logic [23:0] MK = 24'h5A_C3_71; // Arbitrary value
   localparam logic [23:0] PT = 24'h00_4D_2E; // Arbitrary value
   localparam logic [7:0]  IDV [8] = '{8'h01, 8'h00, MK[23:16],
      MK[15:8], MK[7:0], PT[23:16], PT[15:8], PT[7:0]};

   logic                 sys_clk      = 1'b0;
   logic                 sys_rst      = 1'b1;
   logic                 bus_rst      = 1'b0;
   logic                 arb_accel_en = 1'b0;
   logic                 pkt_end      = 1'b0;
   logic [PKT_LEN_W-1:0] pkt_bits     = 16'h0000;
   logic [2:0]           page_select;
   logic                 reg_rd_req;
   logic                 reg_wr_req;
   logic [3:0]           reg_addr;
   logic [7:0]           reg_wdata;
   logic [7:0]           reg_rdata;
   logic                 reg_rd_valid;
   logic                 null_packet_keep_requests;
   phyvr_speed_t         link_speed;
   phyvr_speed_t         selfid_speed;
   phyvr_speed_t         peer_speed_cap;
   logic                 soft_hard_reset;
   logic                 clear_requests;
   int                   fail_count = 0;
   int                   n_checks   = 0;

   always #2.5 sys_clk = ~sys_clk;

   phyvr_top #(.MAKER_ID(MK), .PART_ID(PT)) i_dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .page_select(page_select),
      .reg_rd_req(reg_rd_req), .reg_wr_req(reg_wr_req),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .bus_rst(bus_rst),
      .arb_accel_en(arb_accel_en), .pkt_end(pkt_end),
      .pkt_bits(pkt_bits), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid),
      .null_packet_keep_requests(null_packet_keep_requests),
      .link_speed(link_speed), .selfid_speed(selfid_speed),
      .peer_speed_cap(peer_speed_cap),
      .soft_hard_reset(soft_hard_reset),
      .clear_requests(clear_requests));

   phyvr_llc_model i_llc (
      .sys_clk(sys_clk), .page_select(page_select),
      .reg_rd_req(reg_rd_req), .reg_wr_req(reg_wr_req),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic give_verdict;
      if (fail_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Reads one register and compares answer flag and data
   task automatic rchk(input logic [2:0] pg, input logic [3:0] ad,
                       input logic ev, input logic [7:0] e);
      logic [7:0] d;
      logic       v;
      i_llc.rd(pg, ad, d, v);
      chk("rd_valid", 8'(ev), 8'(v));
      chk("rdata", e, d);
   endtask

   task automatic pkt(input logic [PKT_LEN_W-1:0] b, input logic a,
                      input logic e);
      @(posedge sys_clk);
      pkt_end      <= 1'b1;
      pkt_bits     <= b;
      arb_accel_en <= a;
      @(posedge sys_clk);
      pkt_end      <= 1'b0;
      pkt_bits     <= ~b;
      #1;
      chk("clear_requests", 8'(e), 8'(clear_requests));
   endtask

   initial begin
      repeat (4000) @(posedge sys_clk);
      fail_count++;
      give_verdict();
   end

   initial begin
      int                   n;
      logic [PKT_LEN_W-1:0] b;
      logic                 a;
      logic [PKT_LEN_W-1:0] lens [4];
      lens = '{16'h0000, 16'h0005, 16'h0008, 16'h0009};
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rchk(PG_VENDOR, ADDR_VCTRL, 1'b1, 8'h02);
      for (int i = 0; i < 8; i++) begin
         rchk(PG_IDENT, 4'(8 + i), 1'b1, IDV[i]);
      end
      i_llc.wr(PG_IDENT, ADDR_MAKER_HI, 8'hFF);
      rchk(PG_IDENT, ADDR_MAKER_HI, 1'b1, MK[23:16]);
      rchk(3'h3, 4'h8, 1'b0, 8'h00);
      rchk(PG_IDENT, 4'h7, 1'b0, 8'h00);
      for (int s = 0; s < 4; s++) begin
         i_llc.wr(PG_VENDOR, ADDR_VCTRL, {s[0], 5'h1F, 2'(s)});
         chk("flag", 8'(s[0]), 8'(null_packet_keep_requests));
         chk("link_speed", 8'(s), 8'(link_speed));
         chk("selfid_old", 8'(s == 0 ? 2 : s - 1), 8'(selfid_speed));
         rchk(PG_VENDOR, ADDR_VCTRL, 1'b1, {s[0], 5'h00, 2'(s)});
         chk("selfid", 8'(s), 8'(selfid_speed));
         chk("peer_cap", 8'h02, 8'(peer_speed_cap));
      end
      i_llc.wr(PG_VENDOR, ADDR_VCTRL, 8'h81);
      @(posedge sys_clk);
      bus_rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      bus_rst <= 1'b0;
      rchk(PG_VENDOR, ADDR_VCTRL, 1'b1, 8'h81);
      for (int t = 9; t < 16; t++) begin
         i_llc.wr(PG_VENDOR, 4'(t), t == 14 ? 8'h7F : 8'hFF);
         rchk(PG_VENDOR, 4'(t), 1'b1, 8'h00);
      end
      rchk(PG_VENDOR, ADDR_VCTRL, 1'b1, 8'h81);
      for (int f = 1; f >= 0; f--) begin
         i_llc.wr(PG_VENDOR, ADDR_VCTRL, {f[0], 7'h01});
         for (int k = 0; k < 8; k++) begin
            b = lens[k % 4];
            a = (k >= 4);
            pkt(b, a, (f == 1 && a) ? (b > 8) : (b != 8));
         end
      end
      i_llc.wr(PG_VENDOR, ADDR_SOFT_RESET, 8'h80);
      rchk(PG_VENDOR, ADDR_VCTRL, 1'b0, 8'h00);
      // The refused read above spans the first two reset cycles
      n = 2;
      while (soft_hard_reset === 1'b1 && n < 10) begin
         n++;
         @(posedge sys_clk);
         #1;
      end
      chk("soft_reset_cycles", 8'(SWRST_CYC), 8'(n));
      rchk(PG_VENDOR, ADDR_VCTRL, 1'b1, 8'h02);
      rchk(PG_VENDOR, ADDR_SOFT_RESET, 1'b1, 8'h00);
      give_verdict();
   end
endmodule // phy_vendor_register_pages_bench

`default_nettype wire
